/* File: gpct_top.sv */
// Purpose: Two general-purpose counters and a frequency divider on AHB-Lite.
// Assumes: Pins are asynchronous to MCLK and pass a three-stage filter.
// Notes: Source edges become one-cycle enables inside the MCLK domain.
// Functional notes
// R01: Counter clock taken from any function pin, software picks active edge.
// R02: Without external clock, counter runs from 20 MHz or 100 kHz timebase.
// R03: Counter clock pin mirrors the clock really applied to the counter.
// R04: Gate from any pin, chosen polarity; starts, stops, interrupts, saves.
// R05: Counter gate pin mirrors the gate really applied to the counter; code mirrors the pin level before the gate_fall inversion.
// R06: Output pulses or toggles at terminal count, polarity selectable.
// R07: All counter pins and divider output stay released until enabled.
// R08: Enabled direction line: low counts down, high counts up.
// R09: Direction line can be disabled; software then sets the direction.
// R10: Gate sampled at the active source edge, no hold needed after it.
// R11: Falling-edge counting references gate and output to falling edge.
// R12: Internal timebase leaves gate unsynchronised, one period uncertainty.
// R13: Each output change is launched by the active source edge.
// R14: Divider is a four-bit counter dividing by one to sixteen.
// R15: Divider input picked between 10 MHz and 100 kHz timebases.
// R16: Divider output polarity selectable by software.
// R17: In external DIO clock mode counter 0 output pin becomes an input.
// R18: Counter width and reload are parameters; reload on terminal count.
`timescale 1ns/1ps
module gpct_top #(
   parameter int NPIN = 10,
   parameter int W = 24
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESETN,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // Interrupt
   output logic IRQ,
   // Programmable function pins and direction lines
   input wire logic [NPIN-1:0] PROG_FUNC_PIN_I,
   input wire logic DIGITAL_LINE_SIX_I,
   input wire logic DIGITAL_LINE_SEVEN_I,
   // Counter pins, index is the counter number
   output logic [1:0] COUNTER_CLOCK_O,
   output logic [1:0] COUNTER_CLOCK_OE_N,
   output logic [1:0] COUNTER_GATE_O,
   output logic [1:0] COUNTER_GATE_OE_N,
   output logic [1:0] COUNTER_OUTPUT_O,
   output logic [1:0] COUNTER_OUTPUT_OE_N,
   input wire logic COUNTER0_OUTPUT_I,
   output logic DIO_EXT_CLOCK,
   // Divided clock
   output logic DIVIDED_CLOCK_OUTPUT_O,
   output logic DIVIDED_CLOCK_OUTPUT_OE_N
);
   localparam int NS = NPIN + 3;

   logic [NS-1:0] async_in;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [NS-1:0] s3_q;
   logic [NS-1:0] lvl_q;
   logic [NS-1:0] lvl_p_q;
   logic [gpct_pkg::TB_N-1:0] tick;
   logic accept;
   logic wr_q;
   logic rd_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   gpct_pkg::gpct_cfg_t cfg_q [2];
   logic [W-1:0] load_q [2];
   logic [W-1:0] count [2];
   logic [W-1:0] saved [2];
   logic [1:0] tc_evt;
   logic [1:0] gate_evt;
   gpct_pkg::gpct_freq_t freq_q;
   logic [gpct_pkg::ST_W-1:0] stat_q;
   logic [gpct_pkg::ST_W-1:0] mask_q;
   logic [gpct_pkg::ST_W-1:0] st_set;
   logic [gpct_pkg::ST_W-1:0] st_clr;
   logic [3:0] fcnt_q;
   logic fpulse_q;
   logic ftick;

   // Input filter: a change counts once the second and third stages agree.
   assign async_in = {COUNTER0_OUTPUT_I, DIGITAL_LINE_SEVEN_I,
                      DIGITAL_LINE_SIX_I, PROG_FUNC_PIN_I};
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
         lvl_p_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & lvl_q;
         lvl_p_q <= lvl_q;
      end
   end

   // Timebases come from phase accumulators, so 20 MHz needs no exact divisor
   // of MCLK; the price is a jitter of one MCLK period on each tick.
   for (genvar t = 0; t < gpct_pkg::TB_N; t++) begin : g_tb
      localparam logic [27:0] INC = 28'(gpct_pkg::TB_HZ[t]);
      logic [27:0] acc_q;
      logic [27:0] acc_n;
      assign acc_n = acc_q + INC;
      assign tick[t] = acc_n >= gpct_pkg::ACC_LIMIT;
      always_ff @(posedge MCLK or negedge RESETN) begin
         if (!RESETN) begin
            acc_q <= '0;
         end else begin
            acc_q <= tick[t] ? acc_n - gpct_pkg::ACC_LIMIT : acc_n;
         end
      end
   end

   chk_fast_tick: assert property (@(posedge MCLK) disable iff (!RESETN) // R02
      tick[gpct_pkg::TB_FAST] |=> !tick[gpct_pkg::TB_FAST])
      else $error("20 MHz timebase ticked twice in a row");
   chk_slow_tick: assert property (@(posedge MCLK) disable iff (!RESETN) // R15
      tick[gpct_pkg::TB_SLOW] |=> !tick[gpct_pkg::TB_SLOW] [*8])
      else $error("100 kHz timebase ticked too soon");

   // AHB-Lite: writes finish with no wait, reads take one wait state so
   // that read data always come from a flip-flop.
   assign accept = HSEL & HTRANS[1] & HREADY;
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= '0;
      end else begin
         wr_q <= accept & HWRITE;
         rd_q <= accept & ~HWRITE;
         if (accept) begin
            addr_q <= HADDR[7:0];
         end
      end
   end
   assign HREADYOUT = ~rd_q;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_q;

   always_comb begin
      rd_mux = '0;
      unique case (addr_q)
         gpct_pkg::OFS_CFG: rd_mux = 32'(cfg_q[0]);
         gpct_pkg::OFS_LOAD: rd_mux = 32'(load_q[0]);
         gpct_pkg::OFS_COUNT: rd_mux = 32'(count[0]);
         gpct_pkg::OFS_SAVE: rd_mux = 32'(saved[0]);
         gpct_pkg::CTR_STRIDE + gpct_pkg::OFS_CFG: rd_mux = 32'(cfg_q[1]);
         gpct_pkg::CTR_STRIDE + gpct_pkg::OFS_LOAD: rd_mux = 32'(load_q[1]);
         gpct_pkg::CTR_STRIDE + gpct_pkg::OFS_COUNT: rd_mux = 32'(count[1]);
         gpct_pkg::CTR_STRIDE + gpct_pkg::OFS_SAVE: rd_mux = 32'(saved[1]);
         gpct_pkg::OFS_FREQ: rd_mux = 32'(freq_q);
         gpct_pkg::OFS_STAT: rd_mux = 32'(stat_q);
         gpct_pkg::OFS_MASK: rd_mux = 32'(mask_q);
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         hrdata_q <= '0;
      end else if (rd_q) begin
         hrdata_q <= rd_mux;
      end
   end

   chk_read_wait: assert property (@(posedge MCLK) disable iff (!RESETN)
      accept && !HWRITE |=> !HREADYOUT ##1 HREADYOUT && HRDATA == $past(rd_mux))
      else $error("read did not answer after one wait state");

   // Frequency generator and interrupt mask registers.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         freq_q <= gpct_pkg::FREQ_RST;
         mask_q <= gpct_pkg::ST_RST;
      end else if (wr_q) begin
         if (addr_q == gpct_pkg::OFS_FREQ) begin
            freq_q <= gpct_pkg::FREQ_W'(HWDATA);
         end
         if (addr_q == gpct_pkg::OFS_MASK) begin
            mask_q <= HWDATA[gpct_pkg::ST_W-1:0];
         end
      end
   end

   // Status: bit 2c is terminal count, bit 2c+1 is gate of counter c.
   // A new event in the clearing cycle survives the write-one-to-clear.
   assign st_clr = (wr_q && addr_q == gpct_pkg::OFS_STAT) ?
                   HWDATA[gpct_pkg::ST_W-1:0] : gpct_pkg::ST_RST;
   assign st_set = {gate_evt[1], tc_evt[1], gate_evt[0], tc_evt[0]};
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         stat_q <= gpct_pkg::ST_RST;
      end else begin
         stat_q <= (stat_q & ~st_clr) | st_set;
      end
   end
   // R04 gate raises interrupt
   assign IRQ = |(stat_q & mask_q);

   chk_stat_sticky: assert property (@(posedge MCLK) // R04
      disable iff (!RESETN) ##1 ((stat_q & $past(st_set)) == $past(st_set)))
      else $error("status event lost");

   // R15 divider input select
   assign ftick = freq_q.tb_slow ? tick[gpct_pkg::TB_SLOW] :
                  tick[gpct_pkg::TB_TEN];
   // R14 four-bit divide
   // Divide code n gives one pulse every n+1 timebase periods.
   // Comparing with >= lets a smaller code act at once, with no long wrap.
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         fcnt_q <= '0;
         fpulse_q <= 1'b0;
      end else begin
         fpulse_q <= ftick && fcnt_q >= freq_q.div;
         if (ftick) begin
            fcnt_q <= (fcnt_q >= freq_q.div) ? 4'h0 : fcnt_q + 4'h1;
         end
      end
   end
   // R16 divider polarity
   assign DIVIDED_CLOCK_OUTPUT_O = fpulse_q ^ freq_q.pol;
   // R07 divider released until enabled
   assign DIVIDED_CLOCK_OUTPUT_OE_N = ~freq_q.oe;
   // R17 output pin becomes input
   assign DIO_EXT_CLOCK = lvl_q[NPIN+2];

   chk_dio_release: assert property (@(posedge MCLK) // R17
      disable iff (!RESETN) freq_q.dio_ext_clk |-> COUNTER_OUTPUT_OE_N[0])
      else $error("counter 0 output driven in external DIO clock mode");
   chk_oe_startup: assert property (@(posedge MCLK) // R07
      disable iff (!RESETN) $rose(RESETN) or !$past(RESETN) |->
      &{COUNTER_CLOCK_OE_N, COUNTER_GATE_OE_N, COUNTER_OUTPUT_OE_N,
      DIVIDED_CLOCK_OUTPUT_OE_N})
      else $error("pin driven right after reset");

   for (genvar c = 0; c < 2; c++) begin : g_ch
      localparam logic [7:0] BASE = 8'(c * 16);
      logic clk_now;
      logic clk_prev;
      logic gate_raw;
      logic ext_edge;
      logic src_edge;
      logic dir_up;
      logic clk_mir_q;
      logic gate_mir_q;
      logic out_lvl;
      logic load_hit;

      always_ff @(posedge MCLK or negedge RESETN) begin
         if (!RESETN) begin
            cfg_q[c] <= gpct_pkg::CFG_RST;
            load_q[c] <= '0;
         end else if (wr_q) begin
            if (addr_q == BASE + gpct_pkg::OFS_CFG) begin
               cfg_q[c] <= gpct_pkg::CFG_W'(HWDATA);
            end
            if (addr_q == BASE + gpct_pkg::OFS_LOAD) begin
               load_q[c] <= HWDATA[W-1:0];
            end
         end
      end

      // R01 pin and edge select
      assign clk_now = (cfg_q[c].clk_pin < NPIN) ?
                       lvl_q[cfg_q[c].clk_pin] : 1'b0;
      assign clk_prev = (cfg_q[c].clk_pin < NPIN) ?
                        lvl_p_q[cfg_q[c].clk_pin] : 1'b0;
      // R11 falling edge reference
      assign ext_edge = cfg_q[c].clk_fall ? (clk_prev & ~clk_now) :
                        (clk_now & ~clk_prev);
      // R02 internal timebase source
      assign src_edge = cfg_q[c].clk_ext ? ext_edge :
                        (cfg_q[c].tb_slow ? tick[gpct_pkg::TB_SLOW] :
                         tick[gpct_pkg::TB_FAST]);
      // R04 gate pin and polarity
      assign gate_raw = (cfg_q[c].gate_pin < NPIN) ?
                        lvl_q[cfg_q[c].gate_pin] : 1'b0;
      // R08 external direction line
      // R09 software direction
      assign dir_up = cfg_q[c].dir_ext ? lvl_q[NPIN+c] : cfg_q[c].dir_sw;
      // The load register takes the word at the same edge as the counter,
      // so the counter must be handed the bus word directly.
      assign load_hit = wr_q && addr_q == BASE + gpct_pkg::OFS_LOAD;

      gpct_chan #(
         .W(W)
      ) u_chan (
         .clk(MCLK),
         .rst_n(RESETN),
         .cfg(cfg_q[c]),
         .load_val(load_hit ? HWDATA[W-1:0] : load_q[c]),
         .load_wr(load_hit),
         .src_edge(src_edge),
         .gate_lvl(gate_raw ^ cfg_q[c].gate_fall),
         .dir_up(dir_up),
         .count_q(count[c]),
         .saved_q(saved[c]),
         .out_lvl(out_lvl),
         .tc_evt(tc_evt[c]),
         .gate_evt(gate_evt[c])
      );

      // R03 mirror applied clock
      // R05 mirror gate pin level before gate_fall polarity
      always_ff @(posedge MCLK or negedge RESETN) begin
         if (!RESETN) begin
            clk_mir_q <= 1'b0;
            gate_mir_q <= 1'b0;
         end else begin
            clk_mir_q <= cfg_q[c].clk_ext ? clk_now : src_edge;
            gate_mir_q <= gate_raw;
         end
      end
      assign COUNTER_CLOCK_O[c] = clk_mir_q;
      assign COUNTER_GATE_O[c] = gate_mir_q;
      assign COUNTER_OUTPUT_O[c] = out_lvl;
      // R07 pins released until enabled
      assign COUNTER_CLOCK_OE_N[c] = ~cfg_q[c].oe;
      assign COUNTER_GATE_OE_N[c] = ~cfg_q[c].oe;
      if (c == 0) begin : g_dio
         // R17 release for DIO clock
         assign COUNTER_OUTPUT_OE_N[c] =
            ~(cfg_q[c].oe & ~freq_q.dio_ext_clk);
      end else begin : g_norm
         assign COUNTER_OUTPUT_OE_N[c] = ~cfg_q[c].oe;
      end

      chk_dir_ext: assert property (@(posedge MCLK) // R08
         disable iff (!RESETN) cfg_q[c].dir_ext && !lvl_q[NPIN+c] |-> !dir_up)
         else $error("low direction line did not count down");
      chk_clk_mirror: assert property (@(posedge MCLK) // R03
         disable iff (!RESETN) cfg_q[c].clk_ext && $stable(cfg_q[c]) |=>
         COUNTER_CLOCK_O[c] == $past(clk_now))
         else $error("clock pin does not mirror the applied clock");
   end
endmodule

/* File: gpct_pkg.sv */
// Purpose: Shared constants and types of the general-purpose counter block.
// Assumes: One 125 MHz clock; AHB-Lite register access.
// Notes: Register byte offsets, reset values and timebase rates live here.
package gpct_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   // Timebase order: 20 MHz, 100 kHz, 10 MHz.
   localparam int unsigned TB_N = 3;
   localparam int unsigned TB_FAST = 0;
   localparam int unsigned TB_SLOW = 1;
   localparam int unsigned TB_TEN = 2;
   localparam int unsigned TB_HZ [TB_N] = '{20_000_000, 100_000, 10_000_000};
   localparam logic [27:0] ACC_LIMIT = 28'(CLK_HZ);

   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_LOAD = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_SAVE = 8'h0c;
   localparam logic [7:0] CTR_STRIDE = 8'h10;
   localparam logic [7:0] OFS_FREQ = 8'h20;
   localparam logic [7:0] OFS_STAT = 8'h24;
   localparam logic [7:0] OFS_MASK = 8'h28;
   localparam int unsigned ST_W = 4;
   localparam logic [ST_W-1:0] ST_RST = 4'h0;

   typedef enum logic [1:0] {
      GATE_NONE = 2'b00,
      GATE_LEVEL = 2'b01,
      GATE_STARTSTOP = 2'b10,
      GATE_SAVE = 2'b11
   } gpct_gate_mode_t;

   typedef struct packed {
      logic [3:0] gate_pin;
      logic [3:0] clk_pin;
      logic oe;
      logic dir_sw;
      logic dir_ext;
      logic out_pol;
      logic out_toggle;
      gpct_gate_mode_t gate_mode;
      logic gate_fall;
      logic clk_fall;
      logic clk_ext;
      logic tb_slow;
      logic enable;
   } gpct_cfg_t;
   localparam int unsigned CFG_W = 20;
   localparam gpct_cfg_t CFG_RST = '0;

   typedef struct packed {
      logic dio_ext_clk;
      logic oe;
      logic pol;
      logic tb_slow;
      logic [3:0] div;
   } gpct_freq_t;
   localparam int unsigned FREQ_W = 8;
   localparam gpct_freq_t FREQ_RST = '0;
endpackage

/* File: gpct_chan.sv */
// Purpose: One general-purpose counter with gate handling and output.
// Assumes: src_edge is a one-cycle pulse per active source edge.
// Notes: Every state change waits for src_edge except software load and the run_q clear while disabled.
`timescale 1ns/1ps
module gpct_chan #(
   parameter int W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire gpct_pkg::gpct_cfg_t cfg,
   input wire logic [W-1:0] load_val,
   input wire logic load_wr,
   // Timing inputs
   input wire logic src_edge,
   input wire logic gate_lvl,
   input wire logic dir_up,
   // Results
   output logic [W-1:0] count_q,
   output logic [W-1:0] saved_q,
   output logic out_lvl,
   output logic tc_evt,
   output logic gate_evt
);
   logic gate_smp_q;
   logic run_q;
   logic out_q;
   logic run;
   logic tc_hit;

   // R10 gate sampled at edge
   // R12 unsynchronised gate skew
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_smp_q <= 1'b0;
      end else if (src_edge) begin
         gate_smp_q <= gate_lvl;
      end
   end
   assign gate_evt = src_edge & gate_lvl & ~gate_smp_q & cfg.enable;

   always_comb begin
      unique case (cfg.gate_mode)
         gpct_pkg::GATE_LEVEL: run = cfg.enable & gate_lvl;
         gpct_pkg::GATE_STARTSTOP: run = cfg.enable & run_q;
         default: run = cfg.enable;
      endcase
   end

   // R04 gate starts and stops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 1'b0;
      end else if (!cfg.enable) begin
         run_q <= 1'b0;
      end else if (gate_evt && cfg.gate_mode == gpct_pkg::GATE_STARTSTOP) begin
         run_q <= ~run_q;
      end
   end

   assign tc_hit = dir_up ? (&count_q) : (count_q == '0);
   assign tc_evt = src_edge & run & tc_hit;

   // R18 reload at terminal count
   // R08 direction steers count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (load_wr) begin
         count_q <= load_val;
      end else if (tc_evt) begin
         count_q <= load_val;
      end else if (src_edge && run) begin
         count_q <= dir_up ? count_q + 1'b1 : count_q - 1'b1;
      end
   end

   // R04 gate saves count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         saved_q <= '0;
      end else if (gate_evt && cfg.gate_mode == gpct_pkg::GATE_SAVE) begin
         saved_q <= count_q;
      end
   end

   // R06 pulse or toggle
   // R13 output on source edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b0;
      end else if (src_edge) begin
         out_q <= cfg.out_toggle ? out_q ^ tc_evt : tc_evt;
      end
   end
   assign out_lvl = out_q ^ cfg.out_pol;

   chk_count_hold: assert property (@(posedge clk) disable iff (!rst_n) // R13
      !src_edge && !load_wr |=> $stable(count_q))
      else $error("count moved without a source edge");
   chk_tc_reload: assert property (@(posedge clk) disable iff (!rst_n) // R18
      tc_evt && !load_wr |=> count_q == $past(load_val))
      else $error("terminal count did not reload");
   chk_out_toggle: assert property (@(posedge clk) disable iff (!rst_n) // R06
      tc_evt && cfg.out_toggle |=> out_q != $past(out_q))
      else $error("toggle output missed terminal count");
   chk_gate_edge: assert property (@(posedge clk) disable iff (!rst_n) // R10
      gate_evt |-> src_edge && !gate_smp_q ##1 gate_smp_q)
      else $error("gate acted off a source edge");
endmodule

/* File: gpct_far_side.sv */
// Purpose: Far-side circuitry that drives the function pins.
// Assumes: Pin indices from the bench are below NPIN and differ.
// Notes: Idle pins run a count pattern so a wrong pin pick shows up.
`timescale 1ns/1ps
module gpct_far_side #(
   parameter int NPIN = 10,
   parameter int HALF_NS = 64
) (
   // Bench control
   input wire logic go,
   input wire logic [7:0] ntog,
   input wire logic [3:0] cpin,
   input wire logic [3:0] gpin,
   input wire logic glvl,
   output logic busy,
   // Function pins
   output logic [NPIN-1:0] pins
);
   logic clk_l;
   logic [NPIN-1:0] noise;
   initial begin
      clk_l = 1'b0;
      busy = 1'b0;
      noise = '0;
   end
   always #40 noise = noise + 1'b1;
   // The source clock stands still between bursts, as a real one would.
   always @(posedge go) begin
      busy = 1'b1;
      // Keeps every pin change clear of the sampling clock edge.
      #1;
      repeat (ntog) begin
         #HALF_NS clk_l = ~clk_l;
      end
      #HALF_NS busy = 1'b0;
   end
   always_comb begin
      pins = noise;
      pins[cpin] = clk_l;
      pins[gpin] = glvl;
   end
endmodule

/* File: general_purpose_counter_timing_bench.sv */
// Purpose: Self-checking bench of the two counters and the divider.
// Assumes: The far-side model owns the function pins.
// Notes: Random values come from an LFSR with a fixed seed.
`timescale 1ns/1ps
module general_purpose_counter_timing_bench;
   logic MCLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
   logic [31:0] HADDR, HWDATA, HRDATA, rd, seed;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [9:0] PROG_FUNC_PIN_I;
   logic DIGITAL_LINE_SIX_I, DIGITAL_LINE_SEVEN_I, COUNTER0_OUTPUT_I;
   logic DIO_EXT_CLOCK, DIVIDED_CLOCK_OUTPUT_O, DIVIDED_CLOCK_OUTPUT_OE_N;
   logic [1:0] COUNTER_CLOCK_O, COUNTER_CLOCK_OE_N, COUNTER_GATE_O;
   logic [1:0] COUNTER_GATE_OE_N, COUNTER_OUTPUT_O, COUNTER_OUTPUT_OE_N;
   logic go, glvl, busy, dpol;
   logic [7:0] ntog;
   logic [3:0] cpin, gpin;
   int error_cnt, checks_done, dpul;
   int mir[2];
   wire logic HREADY = HREADYOUT;
   gpct_top uut (.MCLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
      .HWDATA, .HREADY, .HREADYOUT, .HRESP, .HRDATA, .IRQ, .PROG_FUNC_PIN_I,
      .DIGITAL_LINE_SIX_I, .DIGITAL_LINE_SEVEN_I, .COUNTER_CLOCK_O,
      .COUNTER_CLOCK_OE_N, .COUNTER_GATE_O, .COUNTER_GATE_OE_N,
      .COUNTER_OUTPUT_O, .COUNTER_OUTPUT_OE_N, .COUNTER0_OUTPUT_I,
      .DIO_EXT_CLOCK, .DIVIDED_CLOCK_OUTPUT_O, .DIVIDED_CLOCK_OUTPUT_OE_N);
   gpct_far_side far (.go, .ntog, .cpin, .gpin, .glvl, .busy,
      .pins(PROG_FUNC_PIN_I));
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   always @(posedge COUNTER_CLOCK_O[0]) mir[0]++;
   always @(posedge COUNTER_CLOCK_O[1]) mir[1]++;
   always @(posedge MCLK) if (DIVIDED_CLOCK_OUTPUT_O !== dpol) dpul++;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [23:0] nxt(input logic [23:0] c, input int n,
      input logic up);
      return up ? c + 24'(n) : c - 24'(n);
   endfunction
   function automatic int npul(input int t, input logic slow, input int d);
      return (slow ? t / 1250 : t * 2 / 25) / (d + 1);
   endfunction
   function automatic gpct_pkg::gpct_cfg_t base();
      gpct_pkg::gpct_cfg_t c;
      c = '0;
      c.enable = 1'b1;
      c.clk_ext = 1'b1;
      c.oe = 1'b1;
      c.clk_pin = cpin;
      c.gate_pin = gpin;
      return c;
   endfunction
   task automatic print_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= 32'(a);
      HWRITE <= w;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge MCLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task automatic wcfg(input logic [7:0] a, input gpct_pkg::gpct_cfg_t c);
      bus(1'b1, a, {12'h0, c});
   endtask
   // The settle wait covers the pin filter and the mirror flop.
   task automatic tog(input logic [7:0] n);
      ntog <= n;
      go <= 1'b1;
      @(posedge MCLK);
      go <= 1'b0;
      while (busy !== 1'b0) @(posedge MCLK);
      repeat (8) @(posedge MCLK);
   endtask
   task automatic step(input logic [7:0] b, input logic [7:0] t, input int n,
      input logic up, inout logic [23:0] e);
      tog(t);
      e = nxt(e, n, up);
      bus(1'b0, b + 8'h8, 0);
   endtask
   task automatic dl(input int k, input logic v);
      {DIGITAL_LINE_SEVEN_I, DIGITAL_LINE_SIX_I} <= k ? {v, !v} : {!v, v};
   endtask
   task automatic to_tc(output int n);
      n = 0;
      bus(1'b1, 8'h24, 32'h1);
      do begin
         tog(8'h2);
         n++;
         bus(1'b0, 8'h24, 0);
      end while (rd[0] !== 1'b1 && n < 5);
   endtask
   task automatic span(input int t, output int j);
      logic [23:0] e;
      bus(1'b0, 8'h18, 0);
      e = rd[23:0];
      repeat (t) @(posedge MCLK);
      bus(1'b0, 8'h18, 0);
      j = int'(rd[23:0] - e);
   endtask
   task automatic ext(input int k);
      gpct_pkg::gpct_cfg_t c;
      logic [7:0] b;
      logic [23:0] e;
      int m;
      b = 8'(k * 16);
      c = base();
      seed = lfsr(seed);
      e = 24'(seed[7:0]) + 24'h40;
      wcfg(b, c);
      bus(1'b1, b + 8'h4, 32'(e));
      m = mir[k];
      step(b, 8'h6, 3, 1'b0, e);
      chk(rd, 32'(e));
      chk(mir[k] - m, 3);
      c.dir_sw = 1'b1;
      wcfg(b, c);
      step(b, 8'h4, 2, 1'b1, e);
      chk(rd, 32'(e));
      c.dir_ext = 1'b1;
      wcfg(b, c);
      dl(k, 1'b0);
      step(b, 8'h2, 1, 1'b0, e);
      chk(rd, 32'(e));
      dl(k, 1'b1);
      step(b, 8'h2, 1, 1'b1, e);
      chk(rd, 32'(e));
      c.clk_fall = 1'b1;
      wcfg(b, c);
      step(b, 8'h1, 0, 1'b1, e);
      chk(rd, 32'(e));
      step(b, 8'h1, 1, 1'b1, e);
      chk(rd, 32'(e));
   endtask
   initial begin
      repeat (80000) @(posedge MCLK);
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      print_verdict();
   end
   initial begin
      gpct_pkg::gpct_cfg_t c;
      logic [23:0] e;
      logic [3:0] d;
      int n, m, j;
      RESETN = 1'b0;
      HSEL = 1'b0;
      HADDR = '0;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = '0;
      {DIGITAL_LINE_SIX_I, DIGITAL_LINE_SEVEN_I, COUNTER0_OUTPUT_I} = 3'h0;
      {go, glvl, dpol} = 3'h0;
      ntog = 8'h0;
      cpin = 4'h3;
      gpin = 4'h5;
      error_cnt = 0;
      checks_done = 0;
      seed = 32'h5ec0ca29;
      repeat (5) @(posedge MCLK);
      chk({COUNTER_CLOCK_OE_N, COUNTER_GATE_OE_N, COUNTER_OUTPUT_OE_N,
         DIVIDED_CLOCK_OUTPUT_OE_N, IRQ}, 8'hfe);
      RESETN <= 1'b1;
      @(posedge MCLK);
      seed = lfsr(seed);
      bus(1'b1, 8'h10, seed & 32'h77ffe);
      bus(1'b0, 8'h10, 0);
      chk(rd, seed & 32'h77ffe);
      bus(1'b1, 8'h18, seed);
      bus(1'b1, 8'h2c, seed);
      bus(1'b0, 8'h2c, 0);
      chk(rd, 32'h0);
      bus(1'b0, 8'h18, 0);
      chk(rd, 32'h0);
      ext(0);
      ext(1);
      c = base();
      c.gate_mode = gpct_pkg::GATE_SAVE;
      wcfg(8'h00, c);
      bus(1'b1, 8'h24, 32'hf);
      glvl <= 1'b1;
      repeat (10) @(posedge MCLK);
      chk(COUNTER_GATE_O, 2'h3);
      chk({COUNTER_CLOCK_OE_N, COUNTER_GATE_OE_N}, 4'h0);
      bus(1'b0, 8'h24, 0);
      chk(rd[1], 1'b0);
      bus(1'b0, 8'h08, 0);
      e = rd[23:0];
      tog(8'h2);
      bus(1'b0, 8'h24, 0);
      chk(rd[1], 1'b1);
      bus(1'b0, 8'h0c, 0);
      chk(rd, 32'(e));
      c.gate_mode = gpct_pkg::GATE_LEVEL;
      c.gate_fall = 1'b1;
      wcfg(8'h00, c);
      step(8'h00, 8'h2, 0, 1'b0, e);
      chk(rd, 32'(e - 24'h1));
      glvl <= 1'b0;
      c = base();
      c.out_pol = 1'b1;
      wcfg(8'h00, c);
      bus(1'b1, 8'h04, 32'h2);
      repeat (2) @(posedge MCLK);
      chk(COUNTER_OUTPUT_O[0], 1'b1);
      to_tc(n);
      chk(n, 3);
      chk({COUNTER_OUTPUT_O[0], IRQ}, 2'h0);
      bus(1'b1, 8'h28, 32'h1);
      repeat (2) @(posedge MCLK);
      chk(IRQ, 1'b1);
      bus(1'b1, 8'h24, 32'h1);
      repeat (2) @(posedge MCLK);
      chk(IRQ, 1'b0);
      tog(8'h2);
      chk(COUNTER_OUTPUT_O[0], 1'b1);
      c.out_toggle = 1'b1;
      wcfg(8'h00, c);
      to_tc(n);
      chk(COUNTER_OUTPUT_O[0], 1'b0);
      tog(8'h2);
      chk(COUNTER_OUTPUT_O[0], 1'b0);
      c = '0;
      c.enable = 1'b1;
      c.dir_sw = 1'b1;
      wcfg(8'h10, c);
      span(1250, j);
      chk(j >= 198 && j <= 203, 1'b1);
      c.tb_slow = 1'b1;
      wcfg(8'h10, c);
      span(2500, j);
      chk(j >= 1 && j <= 3, 1'b1);
      chk({HRESP, COUNTER_OUTPUT_O[1]}, 2'h0);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         d = (i == 1) ? 4'hf : (i == 2) ? seed[3:0] : 4'h0;
         dpol <= i[0];
         bus(1'b1, 8'h20, {24'h0, 1'b0, 1'b1, i[0], i == 3, d});
         repeat (20) @(posedge MCLK);
         m = dpul;
         repeat (2500) @(posedge MCLK);
         j = dpul - m - npul(2500, i == 3, d);
         chk(j >= -1 && j <= 1, 1'b1);
      end
      chk(DIVIDED_CLOCK_OUTPUT_OE_N, 1'b0);
      bus(1'b1, 8'h20, 32'h80);
      COUNTER0_OUTPUT_I <= 1'b1;
      repeat (8) @(posedge MCLK);
      chk({DIO_EXT_CLOCK, COUNTER_OUTPUT_OE_N[0]}, 2'h3);
      COUNTER0_OUTPUT_I <= 1'b0;
      repeat (8) @(posedge MCLK);
      chk(DIO_EXT_CLOCK, 1'b0);
      print_verdict();
   end
endmodule
